// ==== include/pcsd_pkg.sv ====
package pcsd_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_PLL_CONTROL       = 8'h3C;
  localparam logic [7:0] IDX_CLOCK_SOURCE_SEL  = 8'h3D;
  localparam logic [7:0] IDX_SLOW_CLOCK_DIV    = 8'h3E;
  localparam logic [7:0] IDX_CLOCK_STATUS      = 8'h3F;

  // Field positions of the loop control register.
  localparam int BIT_LOOP_POWER_ON       = 6;
  localparam int BIT_AUTO_BANDWIDTH      = 5;
  localparam int BIT_NOT_ACQUIRING       = 4;
  localparam int BIT_OSC_KEEPALIVE_STOP  = 2;
  localparam int BIT_FALLBACK_IRQ_ENABLE = 1;
  localparam int BIT_DISABLE_FALLBACK    = 0;

  // Field positions of the clock source select register.
  localparam int BIT_SYSTEM_CLOCK_FROM_LOOP    = 6;
  localparam int BIT_SYSTEM_CLOCK_FROM_DIVIDED = 5;
  localparam int BIT_MODULE_CLOCK_SEL    = 2;

  // Divider field and status fields.
  localparam int DIV_MSB                 = 5;
  localparam int BIT_STAT_FALLBACK       = 0;
  localparam int BIT_STAT_MONITOR_RESET  = 1;
  localparam int BIT_STAT_SWITCHING      = 2;
  localparam int BIT_STAT_HIGH_BANDWIDTH = 3;
  localparam int STAT_SOURCE_LSB         = 4;

  // Reset values of the software fields.
  localparam logic       RST_LOOP_POWER_ON     = 1'b1;
  localparam logic       RST_AUTO_BANDWIDTH    = 1'b1;
  localparam logic       RST_DISABLE_FALLBACK  = 1'b0;
  localparam logic [5:0] RST_DIVIDER           = 6'h00;

  // Pin vector positions; every pin passes the three stage synchroniser.
  localparam int PIN_CRYSTAL   = 0;
  localparam int PIN_LOOP_CLK  = 1;
  localparam int PIN_REF_LOST  = 2;
  localparam int PIN_SUPPLY    = 3;
  localparam int PIN_IN_TOL    = 4;
  localparam int PIN_COUNT     = 5;
  localparam logic [4:0] RST_PINS = 5'h08;

  // System clock sources.
  localparam logic [1:0] SRC_CRYSTAL = 2'h0;
  localparam logic [1:0] SRC_DIVIDED = 2'h1;
  localparam logic [1:0] SRC_LOOP    = 2'h2;

  // AHB transfer type bit that marks an active transfer.
  localparam int HTRANS_ACTIVE_BIT = 1;

  typedef enum logic [1:0] {
    SW_RUN   = 2'b00,
    SW_DRAIN = 2'b01,
    SW_ARM   = 2'b11
  } pcsd_switch_t;

endpackage

// ==== core/pcsd_clock_control.sv ====
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
// Operation
// - Loop power stays on while loop drives system
// - Fallback forces loop power, reads latched value
// - Auto bandwidth makes acquisition bit read-only
// - Auto mode picks bandwidth from frequency nearness
// - Auto read: 0 acquiring, 1 tracking
// - Manual: 0 high bandwidth, 1 low
// - Keepalive bit keeps oscillator running in stop
// - Fallback irq enable gated, cleared without supply
// - Reference loss: fallback or monitor reset
// - Disable-fallback write once normally, forced without supply
// - Loop select needs loop power on
// - Fallback forces loop select, reads latched value
// - Divided select ignored while loop selected
// - Module clock: peripheral or slow-derived
// - Fallback forces module select to peripheral
// - Divider write takes effect within one period
// - Slow clock is crystal over twice divider
// - Slow clock keeps fifty percent duty
// - Bus, peripheral, timer clocks halve sources
// - Debug clock half crystal, else bus clock
// - Fallback derives all clocks but divided clock from loop
// - Fallback means reference lost, loop clock used
// - Switching holds clock low and stalls processor
module pcsd_clock_control (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        crystal_clock,
  input  wire logic        loop_output_clock,
  input  wire logic        reference_lost,
  input  wire logic        loop_supply,
  input  wire logic        loop_in_tolerance,
  input  wire logic        special_mode,
  input  wire logic        stop_request,
  output logic             system_clock,
  output logic             cpu_hold,
  output logic             bus_e_clock,
  output logic             periph_clock,
  output logic             timer_base_clock,
  output logic             module_clock,
  output logic             debug_clock,
  output logic             divided_clock,
  output logic             fallback_active,
  output logic             clock_monitor_reset,
  output logic             loop_power_enable,
  output logic             loop_high_bandwidth,
  output logic             oscillator_enable,
  output logic             fallback_irq_enable
);

  typedef struct packed {
    logic [4:0]          s1;
    logic [4:0]          s2;
    logic [4:0]          s3;
    logic [4:0]          lvl;
    logic                ap_valid;
    logic                ap_write;
    logic                ap_mapped;
    logic [7:0]          ap_idx;
    logic [31:0]         hrdata;
    logic                pon;
    logic                auto_bw;
    logic                not_acquiring;
    logic                keepalive;
    logic                irq_en;
    logic                no_fallback;
    logic                no_fallback_done;
    logic                from_loop;
    logic                from_divided;
    logic                mod_sel;
    logic [5:0]          div;
    logic [5:0]          cnt;
    logic                divided;
    pcsd_pkg::pcsd_switch_t sw;
    logic [1:0]          cur;
    logic [1:0]          pend;
    logic                system_clock;
    logic                cpu_hold;
    logic                bus_e;
    logic                periph;
    logic                timer_base;
    logic                module_clock;
    logic                xt_half;
    logic                debug_clock;
    logic                limp;
    logic                cm_reset;
    logic                pon_out;
    logic                high_bw;
    logic                osc_en;
  } pcsd_regs_t;

  pcsd_regs_t st;
  pcsd_regs_t n;

  logic [4:0] pins;
  logic       wr_now;
  logic [7:0] wbyte;
  logic       pon_eff;
  logic       from_loop_eff;
  logic       mod_sel_eff;
  logic [1:0] target;
  logic       xt_rise;
  logic       lp_rise;
  logic       div_rise;
  logic       sys_rise;
  logic       restart;
  logic       slower;
  logic [7:0] rd;

  assign pins = {loop_in_tolerance, loop_supply, reference_lost, loop_output_clock,
                 crystal_clock};

  function automatic logic src_level(input logic [1:0] sel, input logic [4:0] lv,
                                     input logic divl);
    logic r;
    r = lv[pcsd_pkg::PIN_CRYSTAL];
    if (sel == pcsd_pkg::SRC_LOOP) begin
      r = lv[pcsd_pkg::PIN_LOOP_CLK];
    end else if (sel == pcsd_pkg::SRC_DIVIDED) begin
      r = divl;
    end
    return r;
  endfunction

  always_comb begin
    n = st;
    // Pins pass three stages; a level is accepted once stages two and three agree.
    n.s1  = pins;
    n.s2  = st.s1;
    n.s3  = st.s2;
    n.lvl = (st.s2 & st.s3) | (st.lvl & (st.s2 ^ st.s3));
    xt_rise = n.lvl[pcsd_pkg::PIN_CRYSTAL] & ~st.lvl[pcsd_pkg::PIN_CRYSTAL];
    lp_rise = n.lvl[pcsd_pkg::PIN_LOOP_CLK] & ~st.lvl[pcsd_pkg::PIN_LOOP_CLK];

    // Data phase write of the transfer captured in the previous cycle.
    wr_now  = st.ap_valid & st.ap_write & st.ap_mapped;
    wbyte   = hwdata[7:0];
    restart = 1'b0;
    if (wr_now && st.ap_idx == pcsd_pkg::IDX_PLL_CONTROL) begin
      n.pon = wbyte[pcsd_pkg::BIT_LOOP_POWER_ON] | (st.pon & st.from_loop);
      n.auto_bw = wbyte[pcsd_pkg::BIT_AUTO_BANDWIDTH];
      if (!st.auto_bw) begin
        n.not_acquiring = wbyte[pcsd_pkg::BIT_NOT_ACQUIRING];
      end
      n.keepalive = wbyte[pcsd_pkg::BIT_OSC_KEEPALIVE_STOP];
      n.irq_en    = wbyte[pcsd_pkg::BIT_FALLBACK_IRQ_ENABLE];
      if (special_mode || !st.no_fallback_done) begin
        n.no_fallback      = wbyte[pcsd_pkg::BIT_DISABLE_FALLBACK];
        n.no_fallback_done = ~special_mode;
      end
    end
    if (wr_now && st.ap_idx == pcsd_pkg::IDX_CLOCK_SOURCE_SEL) begin
      n.from_loop    = wbyte[pcsd_pkg::BIT_SYSTEM_CLOCK_FROM_LOOP] & st.pon;
      n.from_divided = wbyte[pcsd_pkg::BIT_SYSTEM_CLOCK_FROM_DIVIDED];
      n.mod_sel      = wbyte[pcsd_pkg::BIT_MODULE_CLOCK_SEL];
    end
    if (wr_now && st.ap_idx == pcsd_pkg::IDX_SLOW_CLOCK_DIV) begin
      n.div   = wbyte[pcsd_pkg::DIV_MSB:0];
      restart = 1'b1;
    end
    // Without the loop supply these fields are held at their safe values.
    if (!n.lvl[pcsd_pkg::PIN_SUPPLY]) begin
      n.pon         = 1'b0;
      n.irq_en      = 1'b0;
      n.no_fallback = 1'b1;
    end

    // Loss of the reference either falls back to the loop or asks for a reset.
    n.limp        = n.lvl[pcsd_pkg::PIN_REF_LOST] & ~n.no_fallback;
    n.cm_reset    = n.lvl[pcsd_pkg::PIN_REF_LOST] & n.no_fallback;
    pon_eff       = n.pon | n.limp;
    from_loop_eff = n.from_loop | n.limp;
    mod_sel_eff   = n.mod_sel & ~n.limp;
    n.pon_out     = pon_eff;
    if (from_loop_eff) begin
      target = pcsd_pkg::SRC_LOOP;
    end else if (n.from_divided) begin
      target = pcsd_pkg::SRC_DIVIDED;
    end else begin
      target = pcsd_pkg::SRC_CRYSTAL;
    end

    // Bandwidth: automatic follows the tolerance detector, manual follows software.
    if (n.auto_bw) begin
      n.not_acquiring = n.lvl[pcsd_pkg::PIN_IN_TOL] & pon_eff;
      n.high_bw       = ~n.not_acquiring;
    end else begin
      n.high_bw = ~n.not_acquiring;
    end
    n.osc_en = ~(stop_request & ~n.keepalive);

    // Slow divider; a write restarts the count so the new rate starts at once.
    if (n.div == 6'h00) begin
      n.cnt     = 6'h00;
      n.divided = n.lvl[pcsd_pkg::PIN_CRYSTAL];
    end else if (restart) begin
      n.cnt = 6'h00;
    end else if (xt_rise) begin
      if (st.cnt == n.div - 6'h01) begin
        n.cnt     = 6'h00;
        n.divided = ~st.divided;
      end else begin
        n.cnt = st.cnt + 6'h01;
      end
    end
    div_rise = n.divided & ~st.divided;

    // Source switch: the old source is seen low, then the new one, before it is let through.
    case (st.sw)
      pcsd_pkg::SW_RUN: begin
        if (target != st.cur) begin
          n.pend = target;
          n.sw   = pcsd_pkg::SW_DRAIN;
        end
      end
      pcsd_pkg::SW_DRAIN: begin
        if (!src_level(st.cur, n.lvl, n.divided)) begin
          n.sw = pcsd_pkg::SW_ARM;
        end
      end
      pcsd_pkg::SW_ARM: begin
        if (!src_level(st.pend, n.lvl, n.divided)) begin
          n.cur = st.pend;
          n.sw  = pcsd_pkg::SW_RUN;
        end
      end
      default: begin
        n.sw = pcsd_pkg::SW_RUN;
      end
    endcase
    n.cpu_hold     = (n.sw != pcsd_pkg::SW_RUN);
    n.system_clock = n.cpu_hold ? 1'b0 : src_level(n.cur, n.lvl, n.divided);
    sys_rise       = n.system_clock & ~st.system_clock;

    // Derived clocks toggle on rising edges of their source, halving it.
    if (sys_rise) begin
      n.bus_e  = ~st.bus_e;
      n.periph = ~st.periph;
    end
    if (n.limp ? lp_rise : div_rise) begin
      n.timer_base = ~st.timer_base;
    end
    if (xt_rise) begin
      n.xt_half = ~st.xt_half;
    end
    n.module_clock = mod_sel_eff ? n.timer_base : n.periph;
    slower = ~n.from_loop & n.from_divided & (n.div != 6'h00);
    // In fallback the system clock is the loop, so the bus clock is loop derived.
    n.debug_clock = (n.limp | slower) ? n.bus_e : n.xt_half;

    // Address phase; read data is taken from the next state so a write just ahead is seen.
    n.ap_valid = hsel & hready & htrans[pcsd_pkg::HTRANS_ACTIVE_BIT];
    n.ap_write = hwrite;
    n.ap_idx   = haddr[9:2];
    n.ap_mapped = (haddr[31:10] == 22'h000000) && (haddr[9:2] >= pcsd_pkg::IDX_PLL_CONTROL);
    rd = 8'h00;
    case (haddr[9:2])
      pcsd_pkg::IDX_PLL_CONTROL: begin
        rd[pcsd_pkg::BIT_LOOP_POWER_ON]       = n.pon;
        rd[pcsd_pkg::BIT_AUTO_BANDWIDTH]      = n.auto_bw;
        rd[pcsd_pkg::BIT_NOT_ACQUIRING]       = n.not_acquiring;
        rd[pcsd_pkg::BIT_OSC_KEEPALIVE_STOP]  = n.keepalive;
        rd[pcsd_pkg::BIT_FALLBACK_IRQ_ENABLE] = n.irq_en;
        rd[pcsd_pkg::BIT_DISABLE_FALLBACK]    = n.no_fallback;
      end
      pcsd_pkg::IDX_CLOCK_SOURCE_SEL: begin
        rd[pcsd_pkg::BIT_SYSTEM_CLOCK_FROM_LOOP]    = n.from_loop;
        rd[pcsd_pkg::BIT_SYSTEM_CLOCK_FROM_DIVIDED] = n.from_divided;
        rd[pcsd_pkg::BIT_MODULE_CLOCK_SEL]    = n.mod_sel;
      end
      pcsd_pkg::IDX_SLOW_CLOCK_DIV: begin
        rd[pcsd_pkg::DIV_MSB:0] = n.div;
      end
      pcsd_pkg::IDX_CLOCK_STATUS: begin
        rd[pcsd_pkg::BIT_STAT_FALLBACK]       = n.limp;
        rd[pcsd_pkg::BIT_STAT_MONITOR_RESET]  = n.cm_reset;
        rd[pcsd_pkg::BIT_STAT_SWITCHING]      = n.cpu_hold;
        rd[pcsd_pkg::BIT_STAT_HIGH_BANDWIDTH] = n.high_bw;
        rd[pcsd_pkg::STAT_SOURCE_LSB +: 2]    = n.cur;
      end
      default: begin
        rd = 8'h00;
      end
    endcase
    if (n.ap_valid && !hwrite) begin
      n.hrdata = n.ap_mapped ? {24'h000000, rd} : 32'h00000000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st         <= '0;
      st.s1      <= pcsd_pkg::RST_PINS;
      st.s2      <= pcsd_pkg::RST_PINS;
      st.s3      <= pcsd_pkg::RST_PINS;
      st.lvl     <= pcsd_pkg::RST_PINS;
      st.pon     <= pcsd_pkg::RST_LOOP_POWER_ON;
      st.auto_bw <= pcsd_pkg::RST_AUTO_BANDWIDTH;
      st.no_fallback <= pcsd_pkg::RST_DISABLE_FALLBACK;
      st.div     <= pcsd_pkg::RST_DIVIDER;
      st.sw      <= pcsd_pkg::SW_RUN;
      st.cur     <= pcsd_pkg::SRC_CRYSTAL;
      st.pend    <= pcsd_pkg::SRC_CRYSTAL;
      st.pon_out <= 1'b1;
      st.osc_en  <= 1'b1;
    end else begin
      st <= n;
    end
  end

  // The slave never stalls, so every transfer completes in its first data cycle.
  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;
  assign hrdata              = st.hrdata;
  assign system_clock        = st.system_clock;
  assign cpu_hold            = st.cpu_hold;
  assign bus_e_clock         = st.bus_e;
  assign periph_clock        = st.periph;
  assign timer_base_clock    = st.timer_base;
  assign module_clock        = st.module_clock;
  assign debug_clock         = st.debug_clock;
  assign divided_clock       = st.divided;
  assign fallback_active     = st.limp;
  assign clock_monitor_reset = st.cm_reset;
  assign loop_power_enable   = st.pon_out;
  assign loop_high_bandwidth = st.high_bw;
  assign oscillator_enable   = st.osc_en;
  assign fallback_irq_enable = st.irq_en;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_pon_kept;
    (st.pon && st.from_loop) |=> (st.pon || !st.lvl[pcsd_pkg::PIN_SUPPLY]);
  endproperty
  a_pon_kept: assert property (p_pon_kept) else $error("Loop power cleared while in use.");

  property p_pon_forced;
    st.limp |-> loop_power_enable;
  endproperty
  a_pon_forced: assert property (p_pon_forced) else $error("Loop power not forced.");

  property p_loop_sel_needs_pon;
    (!st.pon && !st.from_loop) |=> !st.from_loop;
  endproperty
  a_loop_sel_needs_pon: assert property (p_loop_sel_needs_pon) else $error("Loop select set unpowered.");

  property p_irq_supply;
    !st.lvl[pcsd_pkg::PIN_SUPPLY] |-> (!fallback_irq_enable && st.no_fallback && !st.pon);
  endproperty
  a_irq_supply: assert property (p_irq_supply) else $error("Supply forcing missing.");

  property p_write_once;
    (st.no_fallback_done && !special_mode && st.lvl[pcsd_pkg::PIN_SUPPLY]) |=>
      (st.no_fallback == $past(st.no_fallback) || !st.lvl[pcsd_pkg::PIN_SUPPLY]);
  endproperty
  a_write_once: assert property (p_write_once) else $error("Second write took effect.");

  property p_loss_split;
    st.lvl[pcsd_pkg::PIN_REF_LOST] |-> (fallback_active != clock_monitor_reset);
  endproperty
  a_loss_split: assert property (p_loss_split) else $error("Reference loss unhandled.");

  property p_bypass;
    (st.div == 6'h00) |-> (divided_clock == st.lvl[pcsd_pkg::PIN_CRYSTAL]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("Zero divider not bypassed.");

  property p_count_range;
    (st.div != 6'h00) |-> (st.cnt < st.div);
  endproperty
  a_count_range: assert property (p_count_range) else $error("Divider count out of range.");

  property p_module_limp;
    st.limp |-> (module_clock == periph_clock);
  endproperty
  a_module_limp: assert property (p_module_limp) else $error("Module clock not peripheral.");

  sequence s_switch_start;
    !cpu_hold ##1 cpu_hold;
  endsequence

  property p_switch_low;
    s_switch_start |-> !system_clock ##1 (!system_clock || !cpu_hold);
  endproperty
  a_switch_low: assert property (p_switch_low) else $error("Clock not held low in switch.");

endmodule

// ==== verification/pcsd_pin_model.sv ====
`timescale 1ns/1ns
// Crystal and loop oscillators at the device pins.
// Both run free while powered, so the block can be seen switching between live sources.
// Their edges sit off the 10 ns grid so that synchronised edge counts stay exact.
module pcsd_pin_model (
  input  wire logic osc_run,
  input  wire logic loop_run,
  output logic      crystal_clock,
  output logic      loop_output_clock
);
  initial begin
    crystal_clock = 1'b0;
    #3;
    forever begin
      #40;
      crystal_clock = osc_run ? ~crystal_clock : 1'b0;
    end
  end

  initial begin
    loop_output_clock = 1'b0;
    #7;
    forever begin
      #30;
      loop_output_clock = loop_run ? ~loop_output_clock : 1'b0;
    end
  end
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/1ns
module testbench;
  logic        ref_clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hresp;
  logic        crystal_clock;
  logic        loop_output_clock;
  logic        reference_lost;
  logic        loop_supply;
  logic        loop_in_tolerance;
  logic        special_mode;
  logic        stop_request;
  logic        system_clock;
  logic        cpu_hold;
  logic        bus_e_clock;
  logic        periph_clock;
  logic        timer_base_clock;
  logic        module_clock;
  logic        debug_clock;
  logic        divided_clock;
  logic        fallback_active;
  logic        clock_monitor_reset;
  logic        loop_power_enable;
  logic        loop_high_bandwidth;
  logic        oscillator_enable;
  logic        fallback_irq_enable;
  logic [6:0]  cv;
  logic        seen_hold;
  int          err_total;
  int          cmp_count;
  int          cycles;
  logic [31:0] rd;

  // Index 0 system, 1 divided, 2 peripheral, 3 bus, 4 timer, 5 module, 6 debug.
  assign cv = {debug_clock, module_clock, timer_base_clock, bus_e_clock,
               periph_clock, divided_clock, system_clock};

  pcsd_clock_control dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .crystal_clock(crystal_clock),
    .loop_output_clock(loop_output_clock), .reference_lost(reference_lost),
    .loop_supply(loop_supply), .loop_in_tolerance(loop_in_tolerance),
    .special_mode(special_mode), .stop_request(stop_request),
    .system_clock(system_clock), .cpu_hold(cpu_hold), .bus_e_clock(bus_e_clock),
    .periph_clock(periph_clock), .timer_base_clock(timer_base_clock),
    .module_clock(module_clock), .debug_clock(debug_clock),
    .divided_clock(divided_clock), .fallback_active(fallback_active),
    .clock_monitor_reset(clock_monitor_reset), .loop_power_enable(loop_power_enable),
    .loop_high_bandwidth(loop_high_bandwidth), .oscillator_enable(oscillator_enable),
    .fallback_irq_enable(fallback_irq_enable));

  pcsd_pin_model pins (
    .osc_run(oscillator_enable), .loop_run(loop_power_enable),
    .crystal_clock(crystal_clock), .loop_output_clock(loop_output_clock));

  always #5 ref_clk = ~ref_clk;

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_total = err_total + 1;
      stop_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("BAD %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // The selected clock must never show a pulse while a source change is in progress.
  always @(negedge ref_clk) begin
    if (cpu_hold === 1'b1) begin
      seen_hold <= 1'b1;
      chk("clock_in_switch", 32'h0, {31'h0, system_clock});
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge ref_clk);
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] mask, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk($sformatf("reg_%0h", idx), {24'h0, exp}, rd & {24'h0, mask});
  endtask

  // Half periods are counted at the falling edge, where registered outputs are settled.
  task automatic meas(input int idx, input int hi, input int lo);
    int n;
    int h;
    int l;
    n = 0;
    h = 0;
    l = 0;
    cyc(120);
    @(negedge ref_clk);
    while (cv[idx] !== 1'b0 && n < 600) begin @(negedge ref_clk); n++; end
    while (cv[idx] !== 1'b1 && n < 600) begin @(negedge ref_clk); n++; end
    while (cv[idx] === 1'b1 && n < 600) begin @(negedge ref_clk); n++; h++; end
    while (cv[idx] === 1'b0 && n < 600) begin @(negedge ref_clk); n++; l++; end
    chk($sformatf("high_%0d", idx), hi, h);
    chk($sformatf("low_%0d", idx), lo, l);
  endtask

  task automatic s_reset();
    rchk(pcsd_pkg::IDX_PLL_CONTROL, 8'hFF, 8'h60);
    rchk(pcsd_pkg::IDX_CLOCK_SOURCE_SEL, 8'hFF, 8'h00);
    rchk(pcsd_pkg::IDX_SLOW_CLOCK_DIV, 8'hFF, 8'h00);
    rchk(8'h00, 8'hFF, 8'h00);
    chk("resp", 32'h0, {31'h0, hresp});
    chk("osc_en", 32'h1, {31'h0, oscillator_enable});
  endtask

  task automatic s_fallback();
    bus(1'b1, pcsd_pkg::IDX_PLL_CONTROL, 8'h20);
    bus(1'b1, pcsd_pkg::IDX_CLOCK_SOURCE_SEL, 8'h44);
    rchk(pcsd_pkg::IDX_CLOCK_SOURCE_SEL, 8'hFF, 8'h04);
    cyc(8);
    chk("pwr_off", 32'h0, {31'h0, loop_power_enable});
    reference_lost <= 1'b1;
    cyc(8);
    chk("fallback", 32'h1, {31'h0, fallback_active});
    chk("mon_rst", 32'h0, {31'h0, clock_monitor_reset});
    chk("pwr_forced", 32'h1, {31'h0, loop_power_enable});
    rchk(pcsd_pkg::IDX_PLL_CONTROL, 8'hFF, 8'h20);
    rchk(pcsd_pkg::IDX_CLOCK_SOURCE_SEL, 8'hFF, 8'h04);
    cyc(60);
    rchk(pcsd_pkg::IDX_CLOCK_STATUS, 8'h31, 8'h21);
    meas(5, 6, 6);
    meas(4, 6, 6);
    reference_lost <= 1'b0;
    cyc(80);
  endtask

  task automatic s_once();
    bus(1'b1, pcsd_pkg::IDX_PLL_CONTROL, 8'h61);
    rchk(pcsd_pkg::IDX_PLL_CONTROL, 8'hFF, 8'h60);
    special_mode <= 1'b1;
    bus(1'b1, pcsd_pkg::IDX_PLL_CONTROL, 8'h61);
    rchk(pcsd_pkg::IDX_PLL_CONTROL, 8'hFF, 8'h61);
    reference_lost <= 1'b1;
    cyc(8);
    chk("mon_rst", 32'h1, {31'h0, clock_monitor_reset});
    chk("no_fallback", 32'h0, {31'h0, fallback_active});
    reference_lost <= 1'b0;
    special_mode <= 1'b0;
    cyc(8);
  endtask

  task automatic s_loop_sel();
    seen_hold = 1'b0;
    bus(1'b1, pcsd_pkg::IDX_CLOCK_SOURCE_SEL, 8'h40);
    rchk(pcsd_pkg::IDX_CLOCK_SOURCE_SEL, 8'hFF, 8'h40);
    cyc(80);
    chk("hold_seen", 32'h1, {31'h0, seen_hold});
    rchk(pcsd_pkg::IDX_CLOCK_STATUS, 8'h34, 8'h20);
    bus(1'b1, pcsd_pkg::IDX_PLL_CONTROL, 8'h21);
    rchk(pcsd_pkg::IDX_PLL_CONTROL, 8'hFF, 8'h61);
    meas(3, 6, 6);
    meas(2, 6, 6);
    meas(0, 3, 3);
    bus(1'b1, pcsd_pkg::IDX_CLOCK_SOURCE_SEL, 8'h00);
    cyc(80);
  endtask

  task automatic s_bandwidth();
    bus(1'b1, pcsd_pkg::IDX_PLL_CONTROL, 8'h41);
    cyc(3);
    chk("high_bw", 32'h1, {31'h0, loop_high_bandwidth});
    bus(1'b1, pcsd_pkg::IDX_PLL_CONTROL, 8'h51);
    cyc(3);
    chk("low_bw", 32'h0, {31'h0, loop_high_bandwidth});
    rchk(pcsd_pkg::IDX_PLL_CONTROL, 8'hFF, 8'h51);
    bus(1'b1, pcsd_pkg::IDX_PLL_CONTROL, 8'h71);
    rchk(pcsd_pkg::IDX_PLL_CONTROL, 8'hFF, 8'h61);
    chk("acq_bw", 32'h1, {31'h0, loop_high_bandwidth});
    loop_in_tolerance <= 1'b1;
    cyc(8);
    rchk(pcsd_pkg::IDX_PLL_CONTROL, 8'hFF, 8'h71);
    chk("track_bw", 32'h0, {31'h0, loop_high_bandwidth});
    loop_in_tolerance <= 1'b0;
  endtask

  task automatic s_stop();
    stop_request <= 1'b1;
    cyc(3);
    chk("osc_stop", 32'h0, {31'h0, oscillator_enable});
    bus(1'b1, pcsd_pkg::IDX_PLL_CONTROL, 8'h65);
    cyc(3);
    chk("osc_keep", 32'h1, {31'h0, oscillator_enable});
    stop_request <= 1'b0;
    cyc(20);
  endtask

  task automatic s_divider();
    bus(1'b1, pcsd_pkg::IDX_SLOW_CLOCK_DIV, 8'h02);
    meas(1, 16, 16);
    meas(4, 32, 32);
    bus(1'b1, pcsd_pkg::IDX_SLOW_CLOCK_DIV, 8'h01);
    meas(1, 8, 8);
    bus(1'b1, pcsd_pkg::IDX_SLOW_CLOCK_DIV, 8'h02);
    bus(1'b1, pcsd_pkg::IDX_CLOCK_SOURCE_SEL, 8'h24);
    meas(3, 32, 32);
    meas(6, 32, 32);
    meas(5, 32, 32);
    bus(1'b1, pcsd_pkg::IDX_CLOCK_SOURCE_SEL, 8'h60);
    meas(3, 6, 6);
    bus(1'b1, pcsd_pkg::IDX_CLOCK_SOURCE_SEL, 8'h00);
    bus(1'b1, pcsd_pkg::IDX_SLOW_CLOCK_DIV, 8'h00);
    meas(1, 4, 4);
    meas(6, 8, 8);
    meas(5, 8, 8);
  endtask

  task automatic s_supply();
    bus(1'b1, pcsd_pkg::IDX_PLL_CONTROL, 8'h63);
    cyc(3);
    chk("irq_en", 32'h1, {31'h0, fallback_irq_enable});
    loop_supply <= 1'b0;
    cyc(8);
    chk("irq_off", 32'h0, {31'h0, fallback_irq_enable});
    rchk(pcsd_pkg::IDX_PLL_CONTROL, 8'h43, 8'h01);
    loop_supply <= 1'b1;
  endtask

  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hsize = 3'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    reference_lost = 1'b0;
    loop_supply = 1'b1;
    loop_in_tolerance = 1'b0;
    special_mode = 1'b0;
    stop_request = 1'b0;
    seen_hold = 1'b0;
    err_total = 0;
    cmp_count = 0;
    cycles = 0;
    cyc(3);
    rst_n <= 1'b1;
    cyc(6);
    s_reset();
    s_fallback();
    s_once();
    s_loop_sel();
    s_bandwidth();
    s_stop();
    s_divider();
    s_supply();
    stop_test();
  end
endmodule
